/* File: common/tcpm_pkg.sv */
// Constants, register map and carrier types of the capture/compare/PWM timer
`default_nettype none
package tcpm_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CNT_W = 16;
   localparam int unsigned PRE_W = 7;
   localparam int unsigned DT_W = 8;
   localparam int unsigned EV_W = 3;

   // Register byte offsets
   localparam logic [7:0] OFS_COUNT = 8'h00;
   localparam logic [7:0] OFS_RELOAD = 8'h04;
   localparam logic [7:0] OFS_CAPPWM = 8'h08;
   localparam logic [7:0] OFS_CTRL0 = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;

   // Values after reset, and count loaded on restart
   localparam logic [15:0] RST_COUNT = 16'h0001;
   localparam logic [15:0] RST_RELOAD = 16'hFFFF;
   localparam logic [15:0] RST_CAPPWM = 16'h0000;
   localparam logic [15:0] RESTART_COUNT = 16'h0001;

   // Status and mask bit positions
   localparam int unsigned EV_IRQ_BIT = 0;
   localparam int unsigned EV_CAP_BIT = 1;
   localparam int unsigned EV_REL_BIT = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Interrupt source selection
   localparam logic [1:0] ISRC_BOTH = 2'h0;
   localparam logic [1:0] ISRC_CAPTURE_ONLY = 2'h1;
   localparam logic [1:0] ISRC_RELOAD_ONLY = 2'h2;

   typedef enum logic [2:0] {
      TCPM_MODE_RELOAD,
      TCPM_MODE_CAPTURE,
      TCPM_MODE_CAPTURE_RESTART,
      TCPM_MODE_CAPTURE_COMPARE,
      TCPM_MODE_GATED,
      TCPM_MODE_COMPARE,
      TCPM_MODE_PWM_SINGLE,
      TCPM_MODE_PWM_DUAL
   } tcpm_mode_t;

   // Timer control zero layout, bit 0 upward: enable, mode, polarity, prescale, isrc, dead time, cause
   typedef struct packed {
      logic [12:0] rsvd;
      logic capture_cause_flag;
      logic [7:0] dead_time_delay;
      logic [1:0] interrupt_source_select;
      logic [2:0] prescale;
      logic input_polarity_select;
      logic [2:0] mode;
      logic enable;
   } tcpm_ctrl_t;

   typedef struct packed {
      logic [7:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [7:0] araddr;
      logic arvalid;
      logic rready;
   } tcpm_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } tcpm_axi_rsp_t;

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] count;
      logic [15:0] reload;
      logic [15:0] cappwm;
      tcpm_ctrl_t ctrl;
      logic [2:0] status;
      logic [2:0] mask;
      logic [6:0] pre_cnt;
      logic tin_prev;
      logic started;
      logic raw;
      logic irq;
   } tcpm_state_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic level;
   } tcpm_dt_state_t;
endpackage
`default_nettype wire

/* File: rtl/tcpm_deadtime.sv */
// Dead-time delay stage: holds back a move to the active level
`timescale 1ns/100ps
`default_nettype none
module tcpm_deadtime #(
   parameter int unsigned DT_W = 8
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic level_i,
   input wire logic active_i,
   input wire logic [DT_W-1:0] delay_i,
   input wire logic init_i,
   output logic level_o
);
   tcpm_pkg::tcpm_dt_state_t s_reg;
   tcpm_pkg::tcpm_dt_state_t s_next;

   always_comb begin
      s_next = s_reg;
      if (level_i == s_reg.level) begin
         s_next.cnt = 8'h00;
      end else if (level_i != active_i) begin
         // Move to inactive level is never delayed
         s_next.level = level_i;
         s_next.cnt = 8'h00;
      end else if (s_reg.cnt >= 8'(delay_i)) begin
         s_next.level = level_i;
         s_next.cnt = 8'h00;
      end else begin
         s_next.cnt = s_reg.cnt + 8'h01;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else if (init_i) begin
         s_reg <= '{cnt: 8'h00, level: level_i};
      end else begin
         s_reg <= s_next;
      end
   end

   assign level_o = s_reg.level;
endmodule
`default_nettype wire

/* File: rtl/tcpm_timer.sv */
// 16-bit capture, compare, gated and PWM timer with AXI4-Lite registers
//
// Summary of operation
// - Capture-restart: selected input edge copies count into capture/PWM register.
// - Capture-restart: capture raises interrupt, reloads count with 0001h, keeps counting.
// - Capture sets capture-cause flag in control zero, distinguishing it from reload.
// - Capture-restart without capture counts up to reload value, then interrupts.
// - Capture-restart counts prescaled system clock; input pin only triggers capture.
// - Capture modes: polarity 0 captures rising edges, 1 falling edges.
// - Single PWM: idle low, high on match, low on reload; polarity inverts.
// - Compare: output equals polarity while disabled, toggles each reload when enabled.
// - Gated: count while input high, interrupt on falling edge; polarity inverts.
// - Capture/compare: first selected edge starts counting, later ones capture.
// - Dual PWM: output and complement opposite, set on match, reversed at reload.
// - Dual PWM: dead time delays each output's move to active level.
// - Interrupt on capture and reload by default; source select restricts it.
// - Counter advances once per two to the prescale field system clocks.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module tcpm_timer #(
   parameter int unsigned DT_W = tcpm_pkg::DT_W
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire tcpm_pkg::tcpm_axi_req_t axi_req_i,
   output tcpm_pkg::tcpm_axi_rsp_t axi_rsp_o,
   input wire logic timer_in_i,
   output logic timer_out_o,
   output logic timer_out_cmp_o,
   output logic irq_o
);
   tcpm_pkg::tcpm_state_t s_reg;
   tcpm_pkg::tcpm_state_t s_next;

   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic wr_go;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [31:0] merged;
   logic pol;
   logic rise;
   logic fall;
   logic sel_edge;
   logic tick;
   logic run;
   logic cap_ev;
   logic rel_ev;
   logic irq_ev;
   logic match;
   logic [6:0] pre_limit;
   logic dual;
   logic dt_init;
   tcpm_pkg::tcpm_mode_t mode;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old_w, input logic [31:0] new_w,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old_w;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_w[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic addr_valid(input logic [7:0] a);
      return (a == tcpm_pkg::OFS_COUNT) || (a == tcpm_pkg::OFS_RELOAD) || (a == tcpm_pkg::OFS_CAPPWM) ||
             (a == tcpm_pkg::OFS_CTRL0) || (a == tcpm_pkg::OFS_STATUS) || (a == tcpm_pkg::OFS_MASK);
   endfunction

   function automatic logic [31:0] read_word(input logic [7:0] a, input tcpm_pkg::tcpm_state_t st);
      logic [31:0] r;
      r = 32'h0000_0000;
      if (a == tcpm_pkg::OFS_COUNT) begin
         r = {16'h0000, st.count};
      end else if (a == tcpm_pkg::OFS_RELOAD) begin
         r = {16'h0000, st.reload};
      end else if (a == tcpm_pkg::OFS_CAPPWM) begin
         r = {16'h0000, st.cappwm};
      end else if (a == tcpm_pkg::OFS_CTRL0) begin
         r = st.ctrl;
      end else if (a == tcpm_pkg::OFS_STATUS) begin
         r = {29'h0000_0000, st.status};
      end else if (a == tcpm_pkg::OFS_MASK) begin
         r = {29'h0000_0000, st.mask};
      end
      return r;
   endfunction

   // Bus handshakes; one write and one read in flight
   assign axi_rsp_o.awready = ~s_reg.aw_got & ~s_reg.bvalid;
   assign axi_rsp_o.wready = ~s_reg.w_got & ~s_reg.bvalid;
   assign axi_rsp_o.arready = ~s_reg.rvalid;
   assign axi_rsp_o.bvalid = s_reg.bvalid;
   assign axi_rsp_o.bresp = s_reg.bresp;
   assign axi_rsp_o.rvalid = s_reg.rvalid;
   assign axi_rsp_o.rdata = s_reg.rdata;
   assign axi_rsp_o.rresp = s_reg.rresp;

   assign aw_hs = axi_req_i.awvalid & axi_rsp_o.awready;
   assign w_hs = axi_req_i.wvalid & axi_rsp_o.wready;
   assign ar_hs = axi_req_i.arvalid & axi_rsp_o.arready;
   assign wr_go = (s_reg.aw_got | aw_hs) & (s_reg.w_got | w_hs);
   assign wr_addr = s_reg.aw_got ? s_reg.aw_addr : axi_req_i.awaddr;
   assign wr_data = s_reg.w_got ? s_reg.w_data : axi_req_i.wdata;
   assign wr_strb = s_reg.w_got ? s_reg.w_strb : axi_req_i.wstrb;
   assign merged = merge_bytes(read_word(wr_addr, s_reg), wr_data, wr_strb);

   assign mode = tcpm_pkg::tcpm_mode_t'(s_reg.ctrl.mode);
   assign pol = s_reg.ctrl.input_polarity_select;
   assign rise = timer_in_i & ~s_reg.tin_prev;
   assign fall = ~timer_in_i & s_reg.tin_prev;
   assign sel_edge = pol ? fall : rise;
   // divide by two to the prescale field
   assign pre_limit = 7'((8'h01 << s_reg.ctrl.prescale) - 8'h01);
   assign tick = s_reg.ctrl.enable & (s_reg.pre_cnt == pre_limit);
   assign match = s_reg.count == s_reg.cappwm;
   assign dual = mode == tcpm_pkg::TCPM_MODE_PWM_DUAL;
   assign dt_init = ~s_reg.ctrl.enable;

   always_comb begin
      s_next = s_reg;
      run = 1'b0;
      cap_ev = 1'b0;
      rel_ev = 1'b0;
      irq_ev = 1'b0;

      // Write channel: address and data taken in either order
      if (aw_hs) begin
         s_next.aw_got = 1'b1;
         s_next.aw_addr = axi_req_i.awaddr;
      end
      if (w_hs) begin
         s_next.w_got = 1'b1;
         s_next.w_data = axi_req_i.wdata;
         s_next.w_strb = axi_req_i.wstrb;
      end
      if (s_reg.bvalid && axi_req_i.bready) begin
         s_next.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = addr_valid(wr_addr) ? tcpm_pkg::RESP_OKAY : tcpm_pkg::RESP_SLVERR;
         if (wr_addr == tcpm_pkg::OFS_COUNT) begin
            s_next.count = merged[15:0];
         end else if (wr_addr == tcpm_pkg::OFS_RELOAD) begin
            s_next.reload = merged[15:0];
         end else if (wr_addr == tcpm_pkg::OFS_CAPPWM) begin
            s_next.cappwm = merged[15:0];
         end else if (wr_addr == tcpm_pkg::OFS_CTRL0) begin
            // Cause flag and reserved bits are not writable
            s_next.ctrl = merged;
            s_next.ctrl.rsvd = '0;
            s_next.ctrl.capture_cause_flag = s_reg.ctrl.capture_cause_flag;
         end else if (wr_addr == tcpm_pkg::OFS_MASK) begin
            s_next.mask = merged[2:0];
         end
      end

      // Read channel; a status read clears it
      if (s_reg.rvalid && axi_req_i.rready) begin
         s_next.rvalid = 1'b0;
      end
      if (ar_hs) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = read_word(axi_req_i.araddr, s_reg);
         s_next.rresp = addr_valid(axi_req_i.araddr) ? tcpm_pkg::RESP_OKAY : tcpm_pkg::RESP_SLVERR;
         if (axi_req_i.araddr == tcpm_pkg::OFS_STATUS) begin
            s_next.status = '0;
         end
      end

      s_next.tin_prev = timer_in_i;

      if (s_reg.ctrl.enable) begin
         s_next.pre_cnt = tick ? 7'h00 : s_reg.pre_cnt + 7'h01;
         // count source is the prescaled clock, gated by mode
         unique case (mode)
            tcpm_pkg::TCPM_MODE_GATED: run = tick & (timer_in_i == ~pol);
            tcpm_pkg::TCPM_MODE_CAPTURE_COMPARE: run = tick & s_reg.started;
            tcpm_pkg::TCPM_MODE_RELOAD,
            tcpm_pkg::TCPM_MODE_CAPTURE,
            tcpm_pkg::TCPM_MODE_CAPTURE_RESTART,
            tcpm_pkg::TCPM_MODE_COMPARE,
            tcpm_pkg::TCPM_MODE_PWM_SINGLE,
            tcpm_pkg::TCPM_MODE_PWM_DUAL: run = tick;
         endcase
         if (run) begin
            if (s_reg.count == s_reg.reload) begin
               rel_ev = 1'b1;
               s_next.count = tcpm_pkg::RESTART_COUNT;
            end else begin
               s_next.count = s_reg.count + 16'h0001;
            end
         end
         unique case (mode)
            tcpm_pkg::TCPM_MODE_CAPTURE,
            tcpm_pkg::TCPM_MODE_CAPTURE_RESTART: begin
               if (sel_edge) begin
                  cap_ev = 1'b1;
                  s_next.cappwm = s_reg.count;
                  if (mode == tcpm_pkg::TCPM_MODE_CAPTURE_RESTART) begin
                     s_next.count = tcpm_pkg::RESTART_COUNT;
                  end
               end
            end
            tcpm_pkg::TCPM_MODE_CAPTURE_COMPARE: begin
               if (sel_edge && !s_reg.started) begin
                  s_next.started = 1'b1;
               end else if (sel_edge) begin
                  cap_ev = 1'b1;
                  s_next.cappwm = s_reg.count;
                  s_next.count = tcpm_pkg::RESTART_COUNT;
               end
            end
            tcpm_pkg::TCPM_MODE_GATED: begin
               if (pol ? rise : fall) begin
                  rel_ev = 1'b1;
               end
            end
            tcpm_pkg::TCPM_MODE_COMPARE: begin
               if (rel_ev) begin
                  s_next.raw = ~s_reg.raw;
               end
            end
            tcpm_pkg::TCPM_MODE_PWM_SINGLE,
            tcpm_pkg::TCPM_MODE_PWM_DUAL: begin
               if (rel_ev) begin
                  s_next.raw = 1'b0;
               end else if (run && match) begin
                  s_next.raw = 1'b1;
               end
            end
            tcpm_pkg::TCPM_MODE_RELOAD: begin
               s_next.raw = s_reg.raw;
            end
         endcase
      end else begin
         s_next.pre_cnt = 7'h00;
         s_next.started = 1'b0;
         s_next.raw = 1'b0;
      end

      if (cap_ev) begin
         s_next.ctrl.capture_cause_flag = 1'b1;
      end else if (rel_ev) begin
         s_next.ctrl.capture_cause_flag = 1'b0;
      end

      irq_ev = (cap_ev && s_reg.ctrl.interrupt_source_select != tcpm_pkg::ISRC_RELOAD_ONLY) ||
               (rel_ev && s_reg.ctrl.interrupt_source_select != tcpm_pkg::ISRC_CAPTURE_ONLY);
      // Sticky sets applied after the read clear so no event is lost
      s_next.status[tcpm_pkg::EV_IRQ_BIT] = s_next.status[tcpm_pkg::EV_IRQ_BIT] | irq_ev;
      s_next.status[tcpm_pkg::EV_CAP_BIT] = s_next.status[tcpm_pkg::EV_CAP_BIT] | cap_ev;
      s_next.status[tcpm_pkg::EV_REL_BIT] = s_next.status[tcpm_pkg::EV_REL_BIT] | rel_ev;
      s_next.irq = |(s_next.status & s_next.mask);
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.count <= tcpm_pkg::RST_COUNT;
         s_reg.reload <= tcpm_pkg::RST_RELOAD;
         s_reg.cappwm <= tcpm_pkg::RST_CAPPWM;
      end else begin
         s_reg <= s_next;
      end
   end

   // output level is raw state xor polarity; dead time only in dual mode
   tcpm_deadtime #(
      .DT_W(DT_W)
   ) u_dt_out (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .level_i(s_reg.raw ^ pol),
      .active_i(~pol),
      .delay_i(dual ? DT_W'(s_reg.ctrl.dead_time_delay) : '0),
      .init_i(dt_init),
      .level_o(timer_out_o)
   );

   tcpm_deadtime #(
      .DT_W(DT_W)
   ) u_dt_cmp (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .level_i(~s_reg.raw ^ pol),
      .active_i(~pol),
      .delay_i(dual ? DT_W'(s_reg.ctrl.dead_time_delay) : '0),
      .init_i(dt_init),
      .level_o(timer_out_cmp_o)
   );

   assign irq_o = s_reg.irq;
endmodule
`default_nettype wire

/* File: test/tcpm_timer_asserts.sv */
// Bus and interrupt checks for the capture, compare and PWM timer
`timescale 1ns/100ps
`default_nettype none
module tcpm_timer_asserts #(
   parameter int unsigned DT_W = 8
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire tcpm_pkg::tcpm_axi_req_t axi_req_i,
   input wire tcpm_pkg::tcpm_axi_rsp_t axi_rsp_o,
   input wire logic timer_in_i,
   input wire logic timer_out_o,
   input wire logic timer_out_cmp_o,
   input wire logic irq_o
);
   logic wr_hs;
   logic rd_hs;
   assign wr_hs = axi_req_i.wvalid && axi_rsp_o.wready;
   assign rd_hs = axi_req_i.arvalid && axi_rsp_o.arready;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (rst_i);
   b_hold_a: assert property (axi_rsp_o.bvalid && !axi_req_i.bready |=>
      axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp)) else $error("write response dropped");
   r_hold_a: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=>
      axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata)) else $error("read data dropped");
   b_answer_a: assert property (wr_hs && axi_req_i.awvalid && axi_rsp_o.awready |=> axi_rsp_o.bvalid)
      else $error("no write response");
   r_answer_a: assert property (rd_hs |=> axi_rsp_o.rvalid) else $error("no read response");
   ar_block_a: assert property (axi_rsp_o.rvalid |-> !axi_rsp_o.arready) else $error("read taken while busy");
   aw_block_a: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready && !axi_rsp_o.wready)
      else $error("write taken while busy");
   bad_addr_a: assert property (rd_hs && axi_req_i.araddr > tcpm_pkg::OFS_MASK |=>
      axi_rsp_o.rresp == tcpm_pkg::RESP_SLVERR && axi_rsp_o.rdata == 32'h0000_0000) else $error("bad read");
   reset_out_a: assert property (disable iff (1'b0) rst_i |=>
      !irq_o && !timer_out_o && !axi_rsp_o.bvalid && !axi_rsp_o.rvalid) else $error("reset levels");
   irq_hold_a: assert property (irq_o && !rd_hs && !$past(rd_hs) && !wr_hs && !$past(wr_hs) |=> irq_o)
      else $error("interrupt fell");
   cover property ($rose(timer_in_i) ##[1:4] $rose(irq_o));
   cover property ($rose(timer_out_o) && !timer_out_cmp_o);
   cover property (rd_hs && axi_req_i.araddr > tcpm_pkg::OFS_MASK);
endmodule
`default_nettype wire

/* File: test/tcpm_pin_model.sv */
// Timer input source: square wave of programmable half period
`timescale 1ns/100ps
`default_nettype none
module tcpm_pin_model (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic idle_i,
   input wire logic [15:0] half_i,
   output logic timer_in_o
);
   logic [15:0] cnt_reg;
   // Sits at the idle level while stopped, so first edge leaves idle
   always_ff @(posedge mclk_i) begin
      if (rst_i || !run_i) begin
         cnt_reg <= 16'h0001;
         timer_in_o <= idle_i;
      end else if (cnt_reg == half_i) begin
         cnt_reg <= 16'h0001;
         timer_in_o <= ~timer_in_o;
      end else begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end
endmodule
`default_nettype wire

/* File: test/timer_capture_pwm_modes_tb_top.sv */
// Self-checking bench for the capture, compare and PWM timer
`timescale 1ns/100ps
`default_nettype none
module timer_capture_pwm_modes_tb_top;
   localparam logic [7:0] AC = tcpm_pkg::OFS_COUNT;
   localparam logic [7:0] AR = tcpm_pkg::OFS_RELOAD;
   localparam logic [7:0] AP = tcpm_pkg::OFS_CAPPWM;
   localparam logic [7:0] AT = tcpm_pkg::OFS_CTRL0;
   localparam logic [7:0] AS = tcpm_pkg::OFS_STATUS;
   localparam logic [7:0] AM = tcpm_pkg::OFS_MASK;
   logic mclk;
   logic rst;
   tcpm_pkg::tcpm_axi_req_t req = '0;
   tcpm_pkg::tcpm_axi_rsp_t rsp;
   logic tin;
   logic tout;
   logic tcmp;
   logic irq;
   logic pin_run = 1'b0;
   logic pin_idle = 1'b0;
   logic [15:0] pin_half = 16'h00C8;
   int cyc = 0;
   int fails = 0;
   int total_checks = 0;
   logic [1:0] wr_resp = 2'h0;
   tcpm_timer u_dut (.mclk_i(mclk), .rst_i(rst), .axi_req_i(req), .axi_rsp_o(rsp), .timer_in_i(tin),
      .timer_out_o(tout), .timer_out_cmp_o(tcmp), .irq_o(irq));
   tcpm_pin_model u_pin (.mclk_i(mclk), .rst_i(rst), .run_i(pin_run), .idle_i(pin_idle),
      .half_i(pin_half), .timer_in_o(tin));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1;
   task automatic results;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic hang;
      fails++;
      results();
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         fails++;
      end
   endtask
   function automatic logic [31:0] ctl(input logic [2:0] m, input logic pol, input logic [2:0] p,
         input logic [1:0] is, input logic [7:0] dt);
      return {14'h0000, dt, is, p, pol, m, 1'b0};
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      logic ah, wh, bh, bb, done;
      @(posedge mclk);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.wvalid <= 1'b1;
      n = 0;
      done = 1'b0;
      // Response taken late on purpose: bready rises only once bvalid is seen
      while (!done && n < 40) begin
         @(negedge mclk);
         ah = req.awvalid && rsp.awready;
         wh = req.wvalid && rsp.wready;
         bh = rsp.bvalid;
         bb = req.bready;
         wr_resp = rsp.bresp;
         @(posedge mclk);
         if (ah) req.awvalid <= 1'b0;
         if (wh) req.wvalid <= 1'b0;
         if (bh) req.bready <= !bb;
         done = bh && bb;
         n++;
      end
      if (!done) hang();
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      logic ah, rh, rr, done;
      @(posedge mclk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      n = 0;
      done = 1'b0;
      while (!done && n < 40) begin
         @(negedge mclk);
         ah = req.arvalid && rsp.arready;
         rh = rsp.rvalid;
         rr = req.rready;
         d = rsp.rdata;
         r = rsp.rresp;
         @(posedge mclk);
         if (ah) req.arvalid <= 1'b0;
         if (rh) req.rready <= !rr;
         done = rh && rr;
         n++;
      end
      if (!done) hang();
   endtask
   task automatic wait_irq(output int t);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(negedge mclk);
         n++;
      end
      t = cyc;
      if (n >= 3000) hang();
   endtask
   task automatic t_reset;
      logic [7:0] ad [7];
      logic [31:0] ex [7];
      logic [31:0] d;
      logic [1:0] r;
      ad = '{AC, AR, AP, AT, AS, AM, 8'h18};
      ex = '{32'h0000_0001, 32'h0000_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
      wr(8'h18, 32'h0000_1234);
      chk({30'h0, wr_resp}, {30'h0, tcpm_pkg::RESP_SLVERR});
      wr(AM, 32'h0000_0000);
      chk({30'h0, wr_resp}, {30'h0, tcpm_pkg::RESP_OKAY});
      for (int i = 0; i < 7; i++) begin
         rd(ad[i], d, r);
         chk(d, ex[i]);
         chk({30'h0, r}, {30'h0, (i == 6) ? tcpm_pkg::RESP_SLVERR : tcpm_pkg::RESP_OKAY});
      end
      $display("reset test done");
   endtask
   task automatic t_cap(input logic [2:0] m, input logic pol);
      logic [31:0] d, c2;
      logic [1:0] r;
      int t;
      pin_idle <= pol;
      pin_half <= 16'h00C8;
      wr(AT, ctl(m, pol, 3'h2, 2'h0, 8'h00));
      wr(AC, 32'h0000_0001);
      wr(AR, 32'h0000_FFFF);
      wr(AP, 32'h0000_0000);
      wr(AM, 32'h0000_0002);
      rd(AS, d, r);
      wr(AT, ctl(m, pol, 3'h2, 2'h0, 8'h00) | 32'h0000_0001);
      repeat (60) @(posedge mclk);
      rd(AC, d, r);
      if (m == 3'h3) chk(d, 32'h0000_0001);
      pin_run <= 1'b1;
      // Wrong-polarity edges fall midway; capturing them would halve the value
      for (int k = 0; k < 3; k++) begin
         wait_irq(t);
         rd(AP, d, r);
         if (k == 2) chk(d, (m == 3'h1) ? c2 + 32'h0000_0064 : c2);
         c2 = d;
         rd(AT, d, r);
         chk({31'h0, d[18]}, 32'h0000_0001);
         rd(AS, d, r);
         chk(d, 32'h0000_0003);
      end
      if (m != 3'h1) chk({31'h0, c2 >= 32'h0000_0063 && c2 <= 32'h0000_0066}, 32'h0000_0001);
      pin_run <= 1'b0;
      wr(AT, 32'h0000_0000);
      $display("capture test mode %0d done", m);
   endtask
   task automatic t_rel(input logic [1:0] is);
      logic [2:0] m;
      logic [31:0] d;
      logic [1:0] r;
      int t1, t2;
      // Last pass runs the plain reload mode with source select 3
      m = (is == 2'h3) ? 3'h0 : 3'h2;
      wr(AT, ctl(m, 1'b0, 3'h2, is, 8'h00));
      wr(AC, 32'h0000_0001);
      wr(AR, 32'h0000_0010);
      wr(AP, 32'h0000_0000);
      wr(AM, 32'h0000_0004);
      rd(AS, d, r);
      wr(AT, ctl(m, 1'b0, 3'h2, is, 8'h00) | 32'h0000_0001);
      wait_irq(t1);
      rd(AS, d, r);
      chk(d, {29'h0, 2'b10, is != 2'h1});
      rd(AT, d, r);
      chk({31'h0, d[18]}, 32'h0000_0000);
      rd(AP, d, r);
      chk(d, 32'h0000_0000);
      wait_irq(t2);
      chk(32'(t2 - t1), 32'h0000_0040);
      wr(AM, 32'h0000_0000);
      repeat (80) @(negedge mclk);
      chk({31'h0, irq}, 32'h0000_0000);
      wr(AT, 32'h0000_0000);
      $display("reload test source %0d done", is);
   endtask
   task automatic t_wave(input logic [2:0] m, input logic pol, input logic [7:0] dt, input int hx, input int tx);
      logic [31:0] c;
      int hi, hc, tr;
      logic po;
      c = ctl(m, pol, 3'h0, 2'h0, dt);
      wr(AT, c);
      wr(AC, 32'h0000_0001);
      wr(AR, 32'h0000_0010);
      wr(AP, 32'h0000_0008);
      repeat (4) @(negedge mclk);
      chk({31'h0, tout}, {31'h0, pol});
      chk({31'h0, tcmp}, {31'h0, ~pol});
      wr(AT, c | 32'h0000_0001);
      repeat (40) @(posedge mclk);
      hi = 0;
      hc = 0;
      tr = 0;
      @(negedge mclk);
      po = tout;
      // Window of four whole periods, so the phase does not matter
      for (int k = 0; k < 64; k++) begin
         @(negedge mclk);
         if (tout === ~pol) hi++;
         if (tcmp === ~pol) hc++;
         if (tout !== po) tr++;
         po = tout;
      end
      chk(32'(hi), 32'(hx));
      chk(32'(tr), 32'(tx));
      if (m == 3'h7) chk(32'(hc), 32'(hx));
      wr(AT, 32'h0000_0000);
      $display("wave test mode %0d done", m);
   endtask
   task automatic t_gate(input logic pol);
      logic [31:0] d, c1;
      logic [1:0] r;
      int t1, t2;
      pin_idle <= pol;
      pin_half <= 16'h0064;
      wr(AT, ctl(3'h4, pol, 3'h0, 2'h0, 8'h00));
      wr(AC, 32'h0000_0001);
      wr(AR, 32'h0000_FFFF);
      wr(AM, 32'h0000_0004);
      rd(AS, d, r);
      wr(AT, ctl(3'h4, pol, 3'h0, 2'h0, 8'h00) | 32'h0000_0001);
      pin_run <= 1'b1;
      wait_irq(t1);
      rd(AC, c1, r);
      rd(AS, d, r);
      chk(d, 32'h0000_0005);
      wait_irq(t2);
      rd(AC, d, r);
      chk(32'(t2 - t1), 32'h0000_00C8);
      chk(d - c1, 32'h0000_0064);
      pin_run <= 1'b0;
      wr(AT, 32'h0000_0000);
      $display("gated test done");
   endtask
   initial begin
      rst = 1'b1;
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      t_reset();
      t_cap(3'h2, 1'b0);
      t_cap(3'h2, 1'b1);
      t_cap(3'h3, 1'b0);
      t_cap(3'h1, 1'b1);
      for (int i = 0; i < 4; i++) t_rel(2'(i));
      t_wave(3'h6, 1'b0, 8'h00, 32, 8);
      t_wave(3'h6, 1'b1, 8'h00, 32, 8);
      t_wave(3'h7, 1'b0, 8'h03, 20, 8);
      t_wave(3'h7, 1'b1, 8'h03, 20, 8);
      t_wave(3'h5, 1'b0, 8'h00, 32, 4);
      t_wave(3'h5, 1'b1, 8'h00, 32, 4);
      t_gate(1'b0);
      t_gate(1'b1);
      results();
   end
   initial begin
      repeat (100000) @(posedge mclk);
      hang();
   end
endmodule
bind tcpm_timer tcpm_timer_asserts #(.DT_W(DT_W)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i), .axi_req_i(axi_req_i),
   .axi_rsp_o(axi_rsp_o), .timer_in_i(timer_in_i), .timer_out_o(timer_out_o),
   .timer_out_cmp_o(timer_out_cmp_o), .irq_o(irq_o));
`default_nettype wire
